// File: iobd_pkg.sv
package iobd_pkg;
    localparam int IOBD_ADDR_W   = 10;
    localparam int IOBD_BASE_LSB = 4;
    localparam int IOBD_SW_W     = 6;
    localparam int IOBD_UNITS    = 4;
    localparam int IOBD_UNIT_LSB = 2;
    localparam logic [1:0] IOBD_CTRL_SEL = 2'h3;
    localparam logic [1:0] IOBD_WAIT_CYCLES = 2'h1;

    typedef struct packed {
        logic [IOBD_ADDR_W-1:0] addr;
        logic                   ior;
        logic                   iow;
        logic                   aen;
    } iobd_bus_s;

    typedef struct packed {
        logic [IOBD_UNITS-1:0] unit_sel;
        logic [1:0]            reg_sel;
        logic                  rd;
        logic                  wr;
    } iobd_sel_s;
endpackage : iobd_pkg

// File: iobd_wait.sv
`timescale 1ns/100ps
module iobd_wait
    import iobd_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic enable,
    input  wire logic hit,
    output logic      not_ready
);
    typedef enum logic [1:0] {IDLE, WAITING, DONE} iobd_wst_e;
    typedef struct packed {
        iobd_wst_e  st;
        logic [1:0] cnt;
    } iobd_wait_s;
    iobd_wait_s s_q, s_d;

    always_comb begin
        s_d = s_q;
        unique case (s_q.st)
            IDLE: begin
                if (hit && enable) begin
                    s_d.st  = WAITING;
                    s_d.cnt = IOBD_WAIT_CYCLES - 2'h1;
                end
            end
            // a dropped strobe re-arms at once, so the next access waits too
            WAITING: begin
                if (!hit) begin
                    s_d.st = IDLE;
                end else if (s_q.cnt == 2'h0) begin
                    s_d.st = DONE;
                end else begin
                    s_d.cnt = s_q.cnt - 2'h1;
                end
            end
            DONE: begin
                if (!hit) begin
                    s_d.st = IDLE;
                end
            end
            default: s_d.st = IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '{st: IDLE, cnt: 2'h0};
        end else begin
            s_q <= s_d;
        end
    end

    // one wait state: ready drops in the first cycle of the access
    assign not_ready = hit && enable &&
                       (s_q.st == IDLE || (s_q.st == WAITING && s_q.cnt != 2'h0));

    property p_wait_one;
        @(posedge clk_sys) disable iff (reset)
        (hit && enable && s_q.st == IDLE) |-> not_ready ##1 (!hit || !not_ready);
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("wait not exactly one");
endmodule : iobd_wait

// File: iobd_decoder.sv
`timescale 1ns/100ps
module iobd_decoder
    import iobd_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire iobd_bus_s            bus,
    input  wire logic [IOBD_SW_W-1:0] switch_on,
    input  wire logic                 wait_enable,
    output iobd_sel_s                 sel,
    output logic                      card_hit,
    output logic                      data_drive,
    output logic                      io_not_ready
);
    typedef struct packed {
        iobd_sel_s sel;
    } iobd_dec_s;
    iobd_dec_s s_q, s_d;

    logic [IOBD_SW_W-1:0] base_bits;
    logic                 match;
    logic                 strobe;
    logic [1:0]           unit_idx;
    logic [1:0]           reg_idx;

    // switch on reads as 0
    assign base_bits = ~switch_on;
    assign match  = bus.addr[IOBD_ADDR_W-1:IOBD_BASE_LSB] == base_bits;
    assign strobe = (bus.ior || bus.iow) && !bus.aen;
    assign card_hit = match && strobe;
    assign unit_idx = bus.addr[IOBD_BASE_LSB-1:IOBD_UNIT_LSB];
    assign reg_idx  = bus.addr[IOBD_UNIT_LSB-1:0];
    // control location never drives the data bus
    assign data_drive = card_hit && bus.ior && (reg_idx != IOBD_CTRL_SEL);

    always_comb begin
        s_d = '0;
        if (card_hit) begin
            s_d.sel.unit_sel = IOBD_UNITS'(1) << unit_idx;
            s_d.sel.reg_sel  = reg_idx;
            s_d.sel.wr       = bus.iow;
            s_d.sel.rd       = bus.ior && (reg_idx != IOBD_CTRL_SEL);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sel = s_q.sel;

    iobd_wait u_wait (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .enable    (wait_enable),
        .hit       (card_hit),
        .not_ready (io_not_ready)
    );

    property p_sel_cause;
        @(posedge clk_sys) disable iff (reset)
        (|sel.unit_sel) |-> $past(card_hit);
    endproperty
    a_sel_cause: assert property (p_sel_cause) else $error("select without hit");

    property p_no_ctrl_read;
        @(posedge clk_sys) disable iff (reset)
        sel.rd |-> sel.reg_sel != IOBD_CTRL_SEL;
    endproperty
    a_no_ctrl_read: assert property (p_no_ctrl_read) else $error("control read");

    property p_unit_map;
        @(posedge clk_sys) disable iff (reset)
        card_hit |=> sel.unit_sel == (IOBD_UNITS'(1) << $past(unit_idx));
    endproperty
    a_unit_map: assert property (p_unit_map) else $error("wrong unit");

    property p_reg_fwd;
        @(posedge clk_sys) disable iff (reset)
        card_hit |=> sel.reg_sel == $past(bus.addr[IOBD_UNIT_LSB-1:0]);
    endproperty
    a_reg_fwd: assert property (p_reg_fwd) else $error("low bits not forwarded");

    property p_match;
        @(posedge clk_sys) disable iff (reset)
        card_hit |-> bus.addr[IOBD_ADDR_W-1:IOBD_BASE_LSB] == ~switch_on;
    endproperty
    a_match: assert property (p_match) else $error("hit outside base");

    property p_dma;
        @(posedge clk_sys) disable iff (reset)
        bus.aen |-> !card_hit && !data_drive;
    endproperty
    a_dma: assert property (p_dma) else $error("hit during dma");

    // steps of one access as seen on the bus
    sequence s_access_open;
        !card_hit ##1 card_hit;
    endsequence

    sequence s_access_close;
        card_hit ##1 !card_hit;
    endsequence

    sequence s_access_hold;
        card_hit ##1 (card_hit && $stable(bus));
    endsequence

    property p_unit_onehot;
        @(posedge clk_sys) disable iff (reset)
        $onehot0(sel.unit_sel);
    endproperty
    a_unit_onehot: assert property (p_unit_onehot) else $error("several units selected");

    property p_sel_follow;
        @(posedge clk_sys) disable iff (reset)
        card_hit |=> $onehot(sel.unit_sel);
    endproperty
    a_sel_follow: assert property (p_sel_follow) else $error("hit left no unit selected");

    property p_sel_release;
        @(posedge clk_sys) disable iff (reset)
        s_access_close |=> sel == '0;
    endproperty
    a_sel_release: assert property (p_sel_release) else $error("select outlived strobe");

    property p_sel_idle;
        @(posedge clk_sys) disable iff (reset)
        !card_hit |=> sel == '0;
    endproperty
    a_sel_idle: assert property (p_sel_idle) else $error("select while idle");

    property p_sel_steady;
        @(posedge clk_sys) disable iff (reset)
        s_access_hold |=> $stable(sel);
    endproperty
    a_sel_steady: assert property (p_sel_steady) else $error("select moved mid access");

    property p_aen_quiet;
        @(posedge clk_sys) disable iff (reset)
        bus.aen |=> sel == '0;
    endproperty
    a_aen_quiet: assert property (p_aen_quiet) else $error("select after dma cycle");

    property p_reset_clear;
        @(posedge clk_sys)
        reset |=> sel == '0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("select survived reset");

    property p_wr_fwd;
        @(posedge clk_sys) disable iff (reset)
        card_hit |=> sel.wr == $past(bus.iow);
    endproperty
    a_wr_fwd: assert property (p_wr_fwd) else $error("write strobe not forwarded");

    property p_rd_fwd;
        @(posedge clk_sys) disable iff (reset)
        card_hit |=> sel.rd == ($past(bus.ior) &&
                                $past(bus.addr[IOBD_UNIT_LSB-1:0]) != IOBD_CTRL_SEL);
    endproperty
    a_rd_fwd: assert property (p_rd_fwd) else $error("read strobe not forwarded");

    property p_drive_read;
        @(posedge clk_sys) disable iff (reset)
        data_drive |-> card_hit && bus.ior;
    endproperty
    a_drive_read: assert property (p_drive_read) else $error("drive outside read");

    property p_drive_ctrl;
        @(posedge clk_sys) disable iff (reset)
        data_drive |-> bus.addr[IOBD_UNIT_LSB-1:0] != IOBD_CTRL_SEL;
    endproperty
    a_drive_ctrl: assert property (p_drive_ctrl) else $error("control location driven");

    property p_read_drive;
        @(posedge clk_sys) disable iff (reset)
        card_hit && bus.ior && (bus.addr[IOBD_UNIT_LSB-1:0] != IOBD_CTRL_SEL) |->
            data_drive;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("port read not driven");

    property p_miss;
        @(posedge clk_sys) disable iff (reset)
        (bus.addr[IOBD_ADDR_W-1:IOBD_BASE_LSB] != ~switch_on) |-> !card_hit && !data_drive;
    endproperty
    a_miss: assert property (p_miss) else $error("claim outside block");

    property p_claim;
        @(posedge clk_sys) disable iff (reset)
        (bus.ior || bus.iow) && !bus.aen &&
        (bus.addr[IOBD_ADDR_W-1:IOBD_BASE_LSB] == ~switch_on) |-> card_hit;
    endproperty
    a_claim: assert property (p_claim) else $error("block not claimed");

    property p_no_strobe;
        @(posedge clk_sys) disable iff (reset)
        !bus.ior && !bus.iow |-> !card_hit && !io_not_ready;
    endproperty
    a_no_strobe: assert property (p_no_strobe) else $error("hit without strobe");

    // wait state: first cycle of every hit while wait_enable is set, never a second one
    property p_wait_first;
        @(posedge clk_sys) disable iff (reset)
        s_access_open ##0 wait_enable |-> io_not_ready;
    endproperty
    a_wait_first: assert property (p_wait_first) else $error("wait state missing");

    property p_wait_single;
        @(posedge clk_sys) disable iff (reset)
        (card_hit && io_not_ready) ##1 card_hit |-> !io_not_ready;
    endproperty
    a_wait_single: assert property (p_wait_single) else $error("wait state too long");

    property p_wait_off;
        @(posedge clk_sys) disable iff (reset)
        !wait_enable |-> !io_not_ready;
    endproperty
    a_wait_off: assert property (p_wait_off) else $error("wait without option");

    property p_wait_cause;
        @(posedge clk_sys) disable iff (reset)
        io_not_ready |-> card_hit;
    endproperty
    a_wait_cause: assert property (p_wait_cause) else $error("wait without hit");

    // one check per unit and per switch, so a swapped line shows by name
    for (genvar u = 0; u < IOBD_UNITS; u++) begin : g_unit_chk
        property p_unit_own;
            @(posedge clk_sys) disable iff (reset)
            card_hit && (bus.addr[IOBD_BASE_LSB-1:IOBD_UNIT_LSB] ==
                (IOBD_BASE_LSB-IOBD_UNIT_LSB)'(u)) |=> sel.unit_sel[u];
        endproperty
        a_unit_own: assert property (p_unit_own) else $error("unit missed its slot");
    end

    for (genvar i = 0; i < IOBD_SW_W; i++) begin : g_switch_chk
        property p_switch_bit;
            @(posedge clk_sys) disable iff (reset)
            card_hit |-> bus.addr[IOBD_BASE_LSB+i] == !switch_on[i];
        endproperty
        a_switch_bit: assert property (p_switch_bit) else $error("switch sense wrong");
    end
endmodule : iobd_decoder

// File: iobd_host.sv
`timescale 1ns/100ps
module iobd_host
    import iobd_pkg::*;
(
    input  wire logic clk_sys,
    output iobd_bus_s bus
);
    initial bus = '0;
    task automatic start(logic [9:0] a, logic rd, logic dma);
        bus = '{addr: a, ior: rd, iow: !rd, aen: dma};
    endtask : start
    // released address lines flip so a stale match cannot pass
    task automatic stop();
        bus = '{addr: ~bus.addr, ior: 1'b0, iow: 1'b0, aen: 1'b0};
    endtask : stop
endmodule : iobd_host

// File: tb.sv
`timescale 1ns/100ps
module tb;
    import iobd_pkg::*;
    typedef struct packed {logic [9:0] a; logic rd; logic dma; logic hit;} iobd_row_s;
    localparam logic Y = 1'b1;
    localparam logic N = 1'b0;
    logic       clk_sys, reset, wait_enable, card_hit, data_drive, io_not_ready;
    logic [5:0] switch_on;
    iobd_bus_s  bus;
    iobd_sel_s  sel;
    int         n_fail, n_tests;
    iobd_row_s  rows[8] = '{'{10'h2d0,Y,N,Y}, '{10'h2d5,Y,N,Y}, '{10'h2db,Y,N,Y},
        '{10'h2df,N,N,Y}, '{10'h2e0,Y,N,N}, '{10'h0d0,Y,N,N}, '{10'h2d3,N,Y,N},
        '{10'h3d4,N,N,N}};
    iobd_host host_u (.clk_sys(clk_sys), .bus(bus));
    iobd_decoder dut_u (.clk_sys(clk_sys), .reset(reset), .bus(bus), .switch_on(switch_on),
        .wait_enable(wait_enable), .sel(sel), .card_hit(card_hit), .data_drive(data_drive),
        .io_not_ready(io_not_ready));
    task automatic chk1(string nm, logic e, logic g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask : chk1
    task automatic chk_sel(logic [9:0] a, logic rd, logic hit);
        iobd_sel_s e;
        e = '0;
        if (hit) begin
            e = '{unit_sel: 4'h1 << a[3:2], reg_sel: a[1:0], rd: rd && a[1:0] != 2'h3, wr: !rd};
        end
        n_tests++;
        if (sel !== e) begin
            n_fail++;
            $display("wrong value sel exp %h got %h", e, sel);
        end
    endtask : chk_sel
    task automatic access(iobd_row_s r, logic w);
        host_u.start(r.a, r.rd, r.dma);
        #1;
        chk1("hit", r.hit, card_hit);
        chk1("drive", r.hit && r.rd && r.a[1:0] != 2'h3, data_drive);
        chk1("wait", r.hit && w, io_not_ready);
        @(posedge clk_sys);
        #2;
        chk_sel(r.a, r.rd, r.hit);
        chk1("wait2", 1'b0, io_not_ready);
        host_u.stop();
        @(posedge clk_sys);
        #2;
        chk1("sel idle", 1'b0, |sel);
        $display("access %h done", r.a);
    endtask : access
    task automatic complete_run();
        $display("tests %0d fails %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial begin
        #50000;
        n_fail++;
        complete_run();
    end
    initial begin
        reset = 1'b1;
        wait_enable = 1'b0;
        switch_on = 6'h12;
        repeat (16) @(posedge clk_sys);
        #2;
        reset = 1'b0;
        chk1("reset sel", 1'b0, |sel);
        $display("reset done");
        foreach (rows[i]) access(rows[i], 1'b0);
        // reset lands on the edge that would latch a hit
        host_u.start(10'h2d1, Y, N);
        reset = 1'b1;
        @(posedge clk_sys);
        #2;
        chk1("mid reset sel", 1'b0, |sel);
        reset = 1'b0;
        @(posedge clk_sys);
        #2;
        chk_sel(10'h2d1, Y, Y);
        host_u.stop();
        @(posedge clk_sys);
        #2;
        $display("mid reset done");
        wait_enable = 1'b1;
        switch_on = 6'h2f;
        access('{10'h10e,Y,N,Y}, 1'b1);
        access('{10'h10f,N,N,Y}, 1'b1);
        // strobe held three cycles: still only one wait state
        host_u.start(10'h106, Y, N);
        #1;
        chk1("long wait", 1'b1, io_not_ready);
        repeat (3) @(posedge clk_sys);
        #2;
        chk1("long wait2", 1'b0, io_not_ready);
        chk1("long drive", 1'b1, data_drive);
        chk_sel(10'h106, Y, Y);
        host_u.stop();
        @(posedge clk_sys);
        #2;
        $display("long access done");
        access('{10'h2d0,Y,N,N}, 1'b1);
        complete_run();
    end
endmodule : tb
